// ### include/shtg_pkg.sv
// Shared constants and types for the stepper home timing gate
package shtg_pkg;

  // Angles in hundredths of a degree
  localparam int unsigned SEQ_CYCLE_CDEG = 720;
  localparam int unsigned FULL_STEP_CDEG = 72;
  localparam int unsigned HALF_STEP_CDEG = 36;
  localparam int unsigned FULL_STEPS = SEQ_CYCLE_CDEG / FULL_STEP_CDEG;
  localparam int unsigned HALF_STEPS = SEQ_CYCLE_CDEG / HALF_STEP_CDEG;
  localparam int unsigned POS_W = 5;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;

  // Control field positions and reset values
  localparam int unsigned CTRL_MODE_BIT = 0;
  localparam int unsigned CTRL_HALF_BIT = 1;
  localparam int unsigned CTRL_RESTART_BIT = 2;
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic CTRL_HALF_RST = 1'b0;

  // Status field positions
  localparam int unsigned STAT_POS_LSB = 0;
  localparam int unsigned STAT_ZERO_BIT = 8;
  localparam int unsigned STAT_FIVE_BIT = 9;
  localparam int unsigned STAT_CLASH_BIT = 10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sequencer move decoded from the pulse inputs
  typedef enum logic [1:0]
  {
    MOVE_HOLD = 2'b00,
    MOVE_FWD = 2'b01,
    MOVE_REV = 2'b10
  } shtg_move_t;

endpackage : shtg_pkg

// ### verilog/shtg_axil.sv
// AXI4-Lite slave front end for the stepper home timing gate
`timescale 1ns/1ps
`default_nettype none
module shtg_axil #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic wr_en_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic rd_en_out,
  output logic [ADDR_W-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } shtg_axil_t;

  shtg_axil_t s_r;
  shtg_axil_t s_nxt;

  // Channels stay closed while a response waits, so one write at a time
  assign awready_out = !s_r.aw_held && !s_r.bvalid;
  assign wready_out = !s_r.w_held && !s_r.bvalid;
  assign arready_out = !s_r.rvalid;
  assign bvalid_out = s_r.bvalid;
  assign bresp_out = s_r.bresp;
  assign rvalid_out = s_r.rvalid;
  assign rdata_out = s_r.rdata;
  assign rresp_out = s_r.rresp;

  // Core strobes: write once both halves are held, read on the handshake
  assign wr_en_out = s_r.aw_held && s_r.w_held;
  assign wr_addr_out = s_r.awaddr;
  assign wr_data_out = s_r.wdata;
  assign wr_strb_out = s_r.wstrb;
  assign rd_en_out = arvalid_in && !s_r.rvalid;
  assign rd_addr_out = araddr_in;

  // Next state of both channel pairs
  always_comb
  begin
    s_nxt = s_r;
    if (awvalid_in && awready_out)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = awaddr_in;
    end
    if (wvalid_in && wready_out)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = wdata_in;
      s_nxt.wstrb = wstrb_in;
    end
    if (wr_en_out)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_ok_in ? shtg_pkg::RESP_OKAY : shtg_pkg::RESP_SLVERR;
    end
    if (s_r.bvalid && bready_in)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (rd_en_out)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data_in;
      s_nxt.rresp = rd_ok_in ? shtg_pkg::RESP_OKAY : shtg_pkg::RESP_SLVERR;
    end
    else if (s_r.rvalid && rready_in)
    begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

endmodule : shtg_axil
`default_nettype wire

// ### verilog/shtg_top.sv
// Excitation sequence tracker with step zero timing output
// Overview of operation
// - Timing flag is high exactly while the sequence sits at step 0.
// - Reset puts the sequence at step 0, so the flag is high at once.
// - Every accepted step pulse moves the sequence by exactly one step, unless a same-cycle restart or resolution change rehomes it.
// - Sequence wraps to step 0 after 7.2 degrees of shaft rotation.
// - Stopping on the flag always leaves the shaft at excitation step 0.
// - Full step 0.72 degrees, half step 0.36 alternating four/five phases.
// - Pulse and direction, or one pulse line per rotation direction.
`timescale 1ns/1ps
`default_nettype none
module shtg_top #(
  parameter int ADDR_W = 8,
  parameter int FULL_STEPS = shtg_pkg::FULL_STEPS,
  parameter int HALF_STEPS = shtg_pkg::HALF_STEPS
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic STEP_PULSE_IN,
  input wire logic STEP_DIR_IN,
  input wire logic CW_PULSE_IN,
  input wire logic CCW_PULSE_IN,
  output logic EXCITATION_STEP_ZERO_FLAG_OUT,
  output logic FIVE_PHASE_OUT,
  input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  output logic [1:0] AXI_BRESP_OUT,
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN
);

  localparam int PW = shtg_pkg::POS_W;
  localparam logic [PW-1:0] FULL_LAST = PW'(FULL_STEPS - 1);
  localparam logic [PW-1:0] HALF_LAST = PW'(HALF_STEPS - 1);

  typedef struct packed {
    logic [PW-1:0] pos;
    logic zero;
    logic five;
    logic mode;
    logic half;
    logic clash;
    logic pulse_q;
    logic cw_q;
    logic ccw_q;
    logic [31:0] count;
  } shtg_core_t;

  // Pulse history resets high so a line already high at release is no step
  localparam shtg_core_t CORE_RST = '{
    pos: '0,
    zero: 1'b1,
    five: 1'b0,
    mode: shtg_pkg::CTRL_MODE_RST,
    half: shtg_pkg::CTRL_HALF_RST,
    clash: 1'b0,
    pulse_q: 1'b1,
    cw_q: 1'b1,
    ccw_q: 1'b1,
    count: '0
  };

  shtg_core_t s_r;
  shtg_core_t s_nxt;
  shtg_pkg::shtg_move_t move;
  logic [PW-1:0] last_pos;
  logic pulse_rise;
  logic cw_rise;
  logic ccw_rise;
  logic clash_now;
  logic ctrl_wr;
  logic clash_clr;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  // Bus front end
  shtg_axil #(
    .ADDR_W(ADDR_W)
  ) u_axil (
    .clk_in(CORE_CLK_IN),
    .rst_in(RST_IN),
    .awaddr_in(AXI_AWADDR_IN),
    .awvalid_in(AXI_AWVALID_IN),
    .awready_out(AXI_AWREADY_OUT),
    .wdata_in(AXI_WDATA_IN),
    .wstrb_in(AXI_WSTRB_IN),
    .wvalid_in(AXI_WVALID_IN),
    .wready_out(AXI_WREADY_OUT),
    .bresp_out(AXI_BRESP_OUT),
    .bvalid_out(AXI_BVALID_OUT),
    .bready_in(AXI_BREADY_IN),
    .araddr_in(AXI_ARADDR_IN),
    .arvalid_in(AXI_ARVALID_IN),
    .arready_out(AXI_ARREADY_OUT),
    .rdata_out(AXI_RDATA_OUT),
    .rresp_out(AXI_RRESP_OUT),
    .rvalid_out(AXI_RVALID_OUT),
    .rready_in(AXI_RREADY_IN),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // Rising edges of the pulse lines
  assign pulse_rise = STEP_PULSE_IN && !s_r.pulse_q;
  assign cw_rise = CW_PULSE_IN && !s_r.cw_q;
  assign ccw_rise = CCW_PULSE_IN && !s_r.ccw_q;

  // Last step of the 7.2 degree cycle for the chosen resolution
  assign last_pos = s_r.half ? HALF_LAST : FULL_LAST;

  // Register writes that touch the sequencer
  assign ctrl_wr = wr_en && (wr_addr == ADDR_W'(shtg_pkg::CTRL_OFS))
    && wr_strb[0];
  assign clash_clr = wr_en && (wr_addr == ADDR_W'(shtg_pkg::STATUS_OFS))
    && wr_strb[1] && wr_data[shtg_pkg::STAT_CLASH_BIT];

  // Offsets that exist accept any write; the rest answer with an error
  assign wr_ok = (wr_addr == ADDR_W'(shtg_pkg::CTRL_OFS))
    || (wr_addr == ADDR_W'(shtg_pkg::STATUS_OFS))
    || (wr_addr == ADDR_W'(shtg_pkg::COUNT_OFS));

  // Pulse decode by input mode
  always_comb
  begin
    move = shtg_pkg::MOVE_HOLD;
    clash_now = 1'b0;
    if (!s_r.mode)
    begin
      // Pulse plus direction level, high means clockwise
      if (pulse_rise)
      begin
        move = STEP_DIR_IN ? shtg_pkg::MOVE_FWD : shtg_pkg::MOVE_REV;
      end
    end
    else
    begin
      // Both lines at once cannot be resolved, so neither moves
      if (cw_rise && ccw_rise)
      begin
        clash_now = 1'b1;
      end
      else if (cw_rise)
      begin
        move = shtg_pkg::MOVE_FWD;
      end
      else if (ccw_rise)
      begin
        move = shtg_pkg::MOVE_REV;
      end
    end
  end

  // Sequencer and register next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pulse_q = STEP_PULSE_IN;
    s_nxt.cw_q = CW_PULSE_IN;
    s_nxt.ccw_q = CCW_PULSE_IN;
    case (move)
      shtg_pkg::MOVE_FWD:
      begin
        s_nxt.pos = (s_r.pos == last_pos) ? '0
          : s_r.pos + PW'(1);
        s_nxt.count = s_r.count + 32'h1;
      end
      shtg_pkg::MOVE_REV:
      begin
        s_nxt.pos = (s_r.pos == '0) ? last_pos
          : s_r.pos - PW'(1);
        s_nxt.count = s_r.count + 32'h1;
      end
      default:
      begin
        s_nxt.pos = s_r.pos;
      end
    endcase
    // A resolution change or a restart would leave a stale phase, so rehome
    if (ctrl_wr)
    begin
      s_nxt.mode = wr_data[shtg_pkg::CTRL_MODE_BIT];
      s_nxt.half = wr_data[shtg_pkg::CTRL_HALF_BIT];
      if (wr_data[shtg_pkg::CTRL_RESTART_BIT]
          || (wr_data[shtg_pkg::CTRL_HALF_BIT] != s_r.half))
      begin
        s_nxt.pos = '0;
      end
    end
    // Clear first, so a clash in the same cycle still sets the flag
    if (clash_clr)
    begin
      s_nxt.clash = 1'b0;
    end
    if (clash_now)
    begin
      s_nxt.clash = 1'b1;
    end
    s_nxt.zero = (s_nxt.pos == '0);
    s_nxt.five = s_nxt.half && s_nxt.pos[0];
  end

  // State register; reset lands on the initial excitation step
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      s_r <= CORE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign EXCITATION_STEP_ZERO_FLAG_OUT = s_r.zero;
  assign FIVE_PHASE_OUT = s_r.five;

  // Read mux; unmapped offsets read zero with an error response
  always_comb
  begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    if (rd_addr == ADDR_W'(shtg_pkg::CTRL_OFS))
    begin
      rd_data[shtg_pkg::CTRL_MODE_BIT] = s_r.mode;
      rd_data[shtg_pkg::CTRL_HALF_BIT] = s_r.half;
    end
    else if (rd_addr == ADDR_W'(shtg_pkg::STATUS_OFS))
    begin
      rd_data[shtg_pkg::STAT_POS_LSB +: PW] = s_r.pos;
      rd_data[shtg_pkg::STAT_ZERO_BIT] = s_r.zero;
      rd_data[shtg_pkg::STAT_FIVE_BIT] = s_r.five;
      rd_data[shtg_pkg::STAT_CLASH_BIT] = s_r.clash;
    end
    else if (rd_addr == ADDR_W'(shtg_pkg::COUNT_OFS))
    begin
      rd_data = s_r.count;
    end
    else
    begin
      rd_ok = 1'b0;
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  flag_step_zero_a: assert property (
    EXCITATION_STEP_ZERO_FLAG_OUT == (s_r.pos == '0))
    else $error("timing flag disagrees with step zero");

  reset_home_a: assert property (
    disable iff (1'b0) RST_IN |=> (EXCITATION_STEP_ZERO_FLAG_OUT
    && s_r.pos == '0 && !FIVE_PHASE_OUT))
    else $error("reset did not return to step zero");

  fwd_one_step_a: assert property (
    (move == shtg_pkg::MOVE_FWD && !ctrl_wr && s_r.pos != last_pos)
    |=> (s_r.pos == $past(s_r.pos) + PW'(1))
    && (s_r.count == $past(s_r.count) + 32'h1))
    else $error("forward pulse did not move one step");

  idle_hold_a: assert property (
    (move == shtg_pkg::MOVE_HOLD && !ctrl_wr) |=> $stable(s_r.pos))
    else $error("position moved without a pulse");

  full_wrap_a: assert property (
    (!s_r.half && s_r.pos == FULL_LAST && move == shtg_pkg::MOVE_FWD
    && !ctrl_wr) |=> (s_r.pos == '0 && EXCITATION_STEP_ZERO_FLAG_OUT))
    else $error("full step cycle did not wrap to zero");

  pos_range_a: assert property (
    s_r.pos <= last_pos)
    else $error("position beyond the 7.2 degree cycle");

  half_alternate_a: assert property (
    (s_r.half && move != shtg_pkg::MOVE_HOLD && !ctrl_wr)
    |=> FIVE_PHASE_OUT != $past(FIVE_PHASE_OUT))
    else $error("half step did not alternate phase count");

  rev_wrap_a: assert property (
    (s_r.pos == '0 && move == shtg_pkg::MOVE_REV && !ctrl_wr)
    |=> (s_r.pos == $past(last_pos) && !EXCITATION_STEP_ZERO_FLAG_OUT))
    else $error("reverse pulse did not wrap to last step");

  dual_ignores_dir_a: assert property (
    (s_r.mode && pulse_rise && !cw_rise && !ccw_rise && !ctrl_wr)
    |=> $stable(s_r.pos))
    else $error("pulse line moved the sequence in dual line mode");

  full_wrap_c: cover property (
    !s_r.half && s_r.pos == FULL_LAST && move == shtg_pkg::MOVE_FWD);
  half_wrap_c: cover property (
    s_r.half && s_r.pos == HALF_LAST && move == shtg_pkg::MOVE_FWD);
  rev_wrap_c: cover property (
    s_r.pos == '0 && move == shtg_pkg::MOVE_REV);
  clash_c: cover property (clash_now);

endmodule : shtg_top
`default_nettype wire

// ### dv/shtg_ctrl_model.sv
// Behavioural motion controller that jogs and homes the step gate
`timescale 1ns/1ps
`default_nettype none
module shtg_ctrl_model #(
  parameter int GAP = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic homing_in,
  input wire logic dir_in,
  input wire logic [7:0] count_in,
  input wire logic home_in,
  input wire logic cw_limit_in,
  input wire logic ccw_limit_in,
  input wire logic zero_flag_in,
  output logic step_out,
  output logic dir_out,
  output logic busy_out
);
  int left_r;
  int gap_r;
  // One high cycle per pulse, then GAP+1 low cycles so the flag has settled
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      step_out <= 1'b0;
      busy_out <= 1'b0;
      dir_out <= 1'b1;
      left_r <= 0;
      gap_r <= 0;
    end
    else if (!busy_out)
    begin
      busy_out <= start_in;
      dir_out <= start_in ? dir_in : dir_out; // Direction held while idle
      left_r <= int'(count_in);
      gap_r <= 0;
    end
    else if (step_out)
    begin
      step_out <= 1'b0;
      gap_r <= GAP;
    end
    else if (gap_r > 0)
      gap_r <= gap_r - 1;
    else if (homing_in ? (home_in && zero_flag_in) : (left_r == 0))
      busy_out <= 1'b0;
    else if (dir_out ? cw_limit_in : ccw_limit_in)
      busy_out <= 1'b0;
    else
    begin
      step_out <= 1'b1;
      left_r <= left_r - 1;
    end
  end
endmodule : shtg_ctrl_model
`default_nettype wire

// ### dv/stepper_home_timing_gate_test.sv
// Self-checking bench for the stepper home timing gate
`timescale 1ns/1ps
`default_nettype none
module stepper_home_timing_gate_test;
  typedef struct {logic [2:0] c; logic up; int n; logic [4:0] p;} shtg_row_t;
  // Control word (restart set), direction, pulses, expected position
  shtg_row_t rows [8] = '{'{3'h4, 1'b1, 1, 5'h01}, '{3'h4, 1'b1, 10, 5'h00},
    '{3'h4, 1'b0, 1, 5'h09}, '{3'h5, 1'b1, 3, 5'h03},
    '{3'h5, 1'b0, 11, 5'h09}, '{3'h6, 1'b1, 19, 5'h13},
    '{3'h6, 1'b1, 20, 5'h00}, '{3'h7, 1'b0, 1, 5'h13}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cw = 1'b0;
  logic ccw = 1'b0;
  logic stp, sdir, flag, five, awr, wr, bv, arr, rv, busy;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, d;
  logic [1:0] br, rr, r;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bq = 1'b0;
  logic arv = 1'b0;
  logic rq = 1'b0;
  logic go = 1'b0;
  logic hm = 1'b0;
  logic gd = 1'b1;
  logic home = 1'b0;
  logic lim = 1'b0;
  logic [7:0] gn = 8'h00;
  int err_total = 0;
  int checks_done = 0;
  int cnt = 0;

  shtg_top dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .STEP_PULSE_IN(stp),
    .STEP_DIR_IN(sdir), .CW_PULSE_IN(cw), .CCW_PULSE_IN(ccw),
    .EXCITATION_STEP_ZERO_FLAG_OUT(flag), .FIVE_PHASE_OUT(five),
    .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv),
    .AXI_WREADY_OUT(wr), .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv),
    .AXI_BREADY_IN(bq), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv),
    .AXI_ARREADY_OUT(arr), .AXI_RDATA_OUT(rd), .AXI_RRESP_OUT(rr),
    .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rq));
  shtg_ctrl_model #(.GAP(1)) mc_u (.clk_in(clk), .rst_in(rst),
    .start_in(go), .homing_in(hm), .dir_in(gd), .count_in(gn),
    .home_in(home), .cw_limit_in(lim), .ccw_limit_in(lim),
    .zero_flag_in(flag), .step_out(stp), .dir_out(sdir), .busy_out(busy));

  // 20 MHz core clock
  always #25 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // Write: both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    bit done;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    done = 0;
    do
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bq && bv)
      begin
        r = br;
        bq <= 1'b0;
        done = 1;
      end
    end while (!done);
  endtask : axw

  // Read: data and response taken at the edge that sees rvalid
  task automatic axr(input logic [7:0] a);
    bit done;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    done = 0;
    do
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rq && rv)
      begin
        d = rd;
        r = rr;
        rq <= 1'b0;
        done = 1;
      end
    end while (!done);
  endtask : axr

  // Dual line pulses: one high cycle, one low cycle each
  task automatic lines(input logic a, input logic b, input int n);
    repeat (n)
    begin
      @(posedge clk);
      cw <= a;
      ccw <= b;
      @(posedge clk);
      cw <= 1'b0;
      ccw <= 1'b0;
    end
    @(posedge clk);
  endtask : lines

  // Hands a jog or homing run to the controller model and waits for it
  task automatic jog(input logic h, input logic up, input int n);
    @(posedge clk);
    go <= 1'b1;
    hm <= h;
    gd <= up;
    gn <= n[7:0];
    @(posedge clk);
    go <= 1'b0;
    // Only the watchdog ends a run that never finishes
    do @(posedge clk); while (busy !== 1'b0);
  endtask : jog

  // Flag, five-phase output and the whole status word against position
  task automatic state(input logic [4:0] p, input logic h);
    chk(32'(flag), 32'(p == 5'h00));
    chk(32'(five), 32'(h & p[0]));
    axr(shtg_pkg::STATUS_OFS);
    chk(d, {21'h0, 1'b0, h & p[0], p == 5'h00, 3'h0, p});
    chk(32'(r), 32'(shtg_pkg::RESP_OKAY));
  endtask : state

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error at %0t: timeout", $time);
    conclude();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    state(5'h00, 1'b0);
    $display("test reset done");
    foreach (rows[i])
    begin
      axw(shtg_pkg::CTRL_OFS, 32'(rows[i].c));
      if (rows[i].c[0])
        lines(rows[i].up, !rows[i].up, rows[i].n);
      else
        jog(1'b0, rows[i].up, rows[i].n);
      cnt += rows[i].n;
      state(rows[i].p, rows[i].c[1]);
      $display("test row %0d done", i);
    end
    // Dual lines: the step line, or both lines together, must not move
    axw(shtg_pkg::CTRL_OFS, 32'h5);
    jog(1'b0, 1'b1, 1);
    lines(1'b1, 1'b1, 1);
    axr(shtg_pkg::STATUS_OFS);
    chk(d, 32'h500);
    axw(shtg_pkg::STATUS_OFS, 32'h400);
    chk(32'(r), 32'(shtg_pkg::RESP_OKAY));
    axr(shtg_pkg::STATUS_OFS);
    chk(d, 32'h100);
    $display("test clash done");
    // Home sensor already active: pulses must run on to step zero
    axw(shtg_pkg::CTRL_OFS, 32'h4);
    jog(1'b0, 1'b1, 3);
    home <= 1'b1;
    jog(1'b1, 1'b1, 0);
    home <= 1'b0;
    cnt += 10;
    state(5'h00, 1'b0);
    axr(shtg_pkg::COUNT_OFS);
    chk(d, 32'(cnt));
    // A travel limit ends a homing run before any pulse goes out
    jog(1'b0, 1'b1, 3);
    lim <= 1'b1;
    jog(1'b1, 1'b1, 0);
    lim <= 1'b0;
    state(5'h03, 1'b0);
    $display("test homing done");
    // Unmapped places answer with an error
    axr(8'h0c);
    chk(d, 32'h0);
    chk(32'(r), 32'(shtg_pkg::RESP_SLVERR));
    axw(8'h10, 32'h7);
    chk(32'(r), 32'(shtg_pkg::RESP_SLVERR));
    $display("test unmapped done");
    // Reset at step 2 in dual line mode returns to step zero and pulse plus direction mode
    axw(shtg_pkg::CTRL_OFS, 32'h5);
    lines(1'b1, 1'b0, 2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    state(5'h00, 1'b0);
    jog(1'b0, 1'b1, 1);
    state(5'h01, 1'b0);
    $display("test second reset done");
    conclude();
  end
endmodule : stepper_home_timing_gate_test
`default_nettype wire
